//--- src/lce_channel.sv
// module: loop channel evaluation top with apb registers
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lce_channel
    import lce_pkg::*;
#(
    parameter int TICK_CYC = int'(LCE_TICK_CYC),
    parameter int RECOVER_TICKS = int'(LCE_RECOVER_TICKS),
    parameter int RETRY_TICKS = int'(LCE_RETRY_TICKS)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // loop measurement front end
    input wire logic loop_occupied,
    input wire logic align_done,
    input wire logic [15:0] switch_on_thr,
    input wire logic pass_valid,
    input wire logic [7:0] atten_len,
    input wire logic pass_rev,
    // hardware address pins
    input wire logic addr_wired,
    input wire logic [6:0] addr_pins,
    // outputs
    output logic oc_high,
    output logic relay_closed,
    output logic [6:0] bus_addr,
    output logic align_active,
    output logic sens_reduced,
    output lce_pkg::lce_vehicle_t telegram
);
    // ---------------------------------------------
    // state and registers
    // ---------------------------------------------
    typedef enum logic [3:0] {
        LCE_IDLE = 4'h1,
        LCE_ALIGN = 4'h2,
        LCE_RUN = 4'h4,
        LCE_FAULT = 4'h8
    } lce_state_t;
    lce_state_t state_reg, state_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [4:0] lencorr_reg, lencorr_next;
    logic [15:0] hold_reg, hold_next;
    logic [15:0] alignmax_reg, alignmax_next;
    logic [15:0] noise_reg, noise_next;
    logic [6:0] addrcfg_reg, addrcfg_next;
    logic [15:0] hold_cnt_reg, hold_cnt_next;
    logic [15:0] align_cnt_reg, align_cnt_next;
    logic [15:0] retry_cnt_reg, retry_cnt_next;
    logic [15:0] rec_cnt_reg, rec_cnt_next;
    logic ignoring_reg, ignoring_next;
    logic [15:0] hold_exp_reg, hold_exp_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    lce_switch_t sw_reg, sw_next;
    logic [6:0] bus_addr_reg, bus_addr_next;
    logic [1:0] occ_sync, wired_sync, done_sync;
    logic [6:0] pins_s1, pins_s2;
    logic tick, occ, done, wr, rd, occ_eff;
    logic [15:0] noise_min, noise_max, noise_eff;
    // ---------------------------------------------
    // pin synchronisers
    // ---------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            occ_sync <= 2'h0;
            wired_sync <= 2'h0;
            done_sync <= 2'h0;
            pins_s1 <= 7'h00;
            pins_s2 <= 7'h00;
        end else begin
            occ_sync <= {occ_sync[0], loop_occupied};
            wired_sync <= {wired_sync[0], addr_wired};
            done_sync <= {done_sync[0], align_done};
            pins_s1 <= addr_pins;
            pins_s2 <= pins_s1;
        end
    end
    assign occ = occ_sync[1];
    assign done = done_sync[1];
    lce_tick #(.CYCLES(TICK_CYC)) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );
    lce_vehicle u_veh (
        .sys_clk(sys_clk),
        .rst(rst),
        .len_corr(lencorr_reg),
        .dir_en(ctrl_reg[LCE_CTRL_DIR_EN]),
        .ww_en(ctrl_reg[LCE_CTRL_WW_EN]),
        .norm_rev(ctrl_reg[LCE_CTRL_NORM_REV]),
        .pass_valid(pass_valid && !ignoring_reg && state_reg == LCE_RUN),
        .atten_len(atten_len),
        .pass_rev(pass_rev),
        .veh(telegram)
    );
    // ---------------------------------------------
    // noise clamp
    // ---------------------------------------------
    always_comb begin
        noise_min = switch_on_thr / LCE_NOISE_MIN_DIV;
        noise_max = 16'(switch_on_thr * LCE_NOISE_MAX_MUL);
        noise_eff = noise_reg;
        if (noise_reg < noise_min) begin
            noise_eff = noise_min;
        end else if (noise_reg > noise_max) begin
            noise_eff = noise_max;
        end
    end
    // ---------------------------------------------
    // apb register file
    // ---------------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next[LCE_CTRL_ALIGN_REQ] = 1'b0;
        lencorr_next = lencorr_reg;
        hold_next = hold_reg;
        alignmax_next = alignmax_reg;
        noise_next = noise_reg;
        addrcfg_next = addrcfg_reg;
        pready_next = psel && !penable;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            case (paddr)
                LCE_ADDR_CTRL, LCE_ADDR_LENCORR, LCE_ADDR_HOLD, LCE_ADDR_ALIGNMAX,
                LCE_ADDR_NOISE, LCE_ADDR_ADDRCFG, LCE_ADDR_STATUS, LCE_ADDR_VEHICLE,
                LCE_ADDR_DIAG: pslverr_next = 1'b0;
                default: pslverr_next = 1'b1;
            endcase
        end
        if (rd) begin
            case (paddr)
                LCE_ADDR_CTRL: prdata_next = ctrl_reg;
                LCE_ADDR_LENCORR: prdata_next = {27'h0, lencorr_reg};
                LCE_ADDR_HOLD: prdata_next = {16'h0, hold_reg};
                LCE_ADDR_ALIGNMAX: prdata_next = {16'h0, alignmax_reg};
                LCE_ADDR_NOISE: prdata_next = {noise_eff, noise_reg};
                LCE_ADDR_ADDRCFG: prdata_next = {25'h0, bus_addr_reg};
                LCE_ADDR_STATUS: prdata_next = {24'h0, state_reg, sens_reduced,
                    ignoring_reg, (state_reg == LCE_FAULT), occ};
                LCE_ADDR_VEHICLE: prdata_next = {19'h0, telegram};
                LCE_ADDR_DIAG: prdata_next = {align_cnt_reg, hold_exp_reg};
                default: prdata_next = 32'h0;
            endcase
        end
        if (wr) begin
            case (paddr)
                LCE_ADDR_CTRL: ctrl_next = pwdata;
                LCE_ADDR_LENCORR: lencorr_next = (pwdata[4:0] > LCE_LENCORR_MAX) ?
                    LCE_LENCORR_MAX : pwdata[4:0];
                LCE_ADDR_HOLD: hold_next = pwdata[15:0];
                LCE_ADDR_ALIGNMAX: alignmax_next = pwdata[15:0];
                LCE_ADDR_NOISE: noise_next = pwdata[15:0];
                LCE_ADDR_ADDRCFG: addrcfg_next = pwdata[6:0];
                default: ctrl_next = ctrl_next;
            endcase
        end
    end
    // ---------------------------------------------
    // channel supervision
    // ---------------------------------------------
    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        align_cnt_next = align_cnt_reg;
        retry_cnt_next = retry_cnt_reg;
        rec_cnt_next = rec_cnt_reg;
        ignoring_next = ignoring_reg;
        hold_exp_next = hold_exp_reg;
        case (state_reg)
            LCE_IDLE: begin
                state_next = LCE_ALIGN;
                align_cnt_next = 16'h0;
            end
            LCE_ALIGN: begin
                if (tick) begin
                    align_cnt_next = align_cnt_reg + 16'h1;
                end
                if (done) begin
                    state_next = LCE_RUN;
                    hold_cnt_next = 16'h0;
                end else if (alignmax_reg != 16'h0 && align_cnt_reg >= alignmax_reg) begin
                    state_next = LCE_FAULT;
                    retry_cnt_next = 16'h0;
                end
            end
            LCE_RUN: begin
                if (!occ) begin
                    hold_cnt_next = 16'h0;
                end else if (tick && hold_reg != 16'h0 && !ignoring_reg) begin
                    hold_cnt_next = hold_cnt_reg + 16'h1;
                    if (hold_cnt_reg + 16'h1 >= hold_reg) begin
                        ignoring_next = 1'b1;
                        hold_exp_next = hold_exp_reg + 16'h1;
                        state_next = LCE_IDLE;
                    end
                end
                if (ignoring_reg) begin
                    if (occ) begin
                        rec_cnt_next = 16'h0;
                    end else if (tick) begin
                        rec_cnt_next = rec_cnt_reg + 16'h1;
                        if (rec_cnt_reg + 16'h1 >= 16'(RECOVER_TICKS)) begin
                            ignoring_next = 1'b0;
                            rec_cnt_next = 16'h0;
                        end
                    end
                end
            end
            LCE_FAULT: begin
                if (ctrl_reg[LCE_CTRL_AUTO_REAL] && tick) begin
                    retry_cnt_next = retry_cnt_reg + 16'h1;
                    if (retry_cnt_reg + 16'h1 >= 16'(RETRY_TICKS)) begin
                        state_next = LCE_IDLE;
                    end
                end
            end
            default: state_next = LCE_IDLE;
        endcase
        if (ctrl_reg[LCE_CTRL_ALIGN_REQ]) begin
            state_next = LCE_IDLE;
        end
    end
    // ---------------------------------------------
    // switching output and address
    // ---------------------------------------------
    always_comb begin
        occ_eff = (state_reg == LCE_FAULT) ? !ctrl_reg[LCE_CTRL_ERR_FREE]
            : (occ && !ignoring_reg);
        sw_next.oc_high = ctrl_reg[LCE_CTRL_POL_NC] ^ !occ_eff;
        sw_next.relay_closed = ctrl_reg[LCE_CTRL_POL_NC] ^ occ_eff;
        bus_addr_next = wired_sync[1] ? pins_s2 : addrcfg_reg;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= LCE_IDLE;
            ctrl_reg <= LCE_CTRL_RESET;
            lencorr_reg <= 5'h00;
            hold_reg <= 16'h0;
            alignmax_reg <= 16'h0;
            noise_reg <= 16'h0;
            addrcfg_reg <= LCE_ADDR_DEFAULT;
            hold_cnt_reg <= 16'h0;
            align_cnt_reg <= 16'h0;
            retry_cnt_reg <= 16'h0;
            rec_cnt_reg <= 16'h0;
            ignoring_reg <= 1'b0;
            hold_exp_reg <= 16'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            sw_reg <= '{relay_closed: 1'b1, oc_high: 1'b0};
            bus_addr_reg <= LCE_ADDR_DEFAULT;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            lencorr_reg <= lencorr_next;
            hold_reg <= hold_next;
            alignmax_reg <= alignmax_next;
            noise_reg <= noise_next;
            addrcfg_reg <= addrcfg_next;
            hold_cnt_reg <= hold_cnt_next;
            align_cnt_reg <= align_cnt_next;
            retry_cnt_reg <= retry_cnt_next;
            rec_cnt_reg <= rec_cnt_next;
            ignoring_reg <= ignoring_next;
            hold_exp_reg <= hold_exp_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            sw_reg <= sw_next;
            bus_addr_reg <= bus_addr_next;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign oc_high = sw_reg.oc_high;
    assign relay_closed = sw_reg.relay_closed;
    assign bus_addr = bus_addr_reg;
    assign align_active = (state_reg == LCE_ALIGN);
    assign sens_reduced = ignoring_reg;
endmodule
`default_nettype wire

//--- src/lce_pkg.sv
// package: register map, field layouts, timing constants for loop channel evaluation
package lce_pkg;
    // ---------------------------------------------
    // register byte addresses
    // ---------------------------------------------
    localparam logic [7:0] LCE_ADDR_CTRL = 8'h00;
    localparam logic [7:0] LCE_ADDR_LENCORR = 8'h04;
    localparam logic [7:0] LCE_ADDR_HOLD = 8'h08;
    localparam logic [7:0] LCE_ADDR_ALIGNMAX = 8'h0C;
    localparam logic [7:0] LCE_ADDR_NOISE = 8'h10;
    localparam logic [7:0] LCE_ADDR_ADDRCFG = 8'h14;
    localparam logic [7:0] LCE_ADDR_STATUS = 8'h18;
    localparam logic [7:0] LCE_ADDR_VEHICLE = 8'h1C;
    localparam logic [7:0] LCE_ADDR_DIAG = 8'h20;
    // ---------------------------------------------
    // control register fields
    // ---------------------------------------------
    localparam int LCE_CTRL_WW_EN = 0;
    localparam int LCE_CTRL_DIR_EN = 1;
    localparam int LCE_CTRL_NORM_REV = 2;
    localparam int LCE_CTRL_POL_NC = 3;
    localparam int LCE_CTRL_ERR_FREE = 4;
    localparam int LCE_CTRL_AUTO_REAL = 5;
    localparam int LCE_CTRL_ALIGN_REQ = 6;
    localparam logic [31:0] LCE_CTRL_RESET = 32'h0000_0002;
    // ---------------------------------------------
    // value limits and defaults
    // ---------------------------------------------
    localparam logic [4:0] LCE_LENCORR_MAX = 5'h14;
    localparam logic [15:0] LCE_NOISE_MIN_DIV = 16'h0004;
    localparam logic [15:0] LCE_NOISE_MAX_MUL = 16'h0002;
    localparam logic [6:0] LCE_ADDR_DEFAULT = 7'h01;
    // ---------------------------------------------
    // timing
    // ---------------------------------------------
    localparam longint LCE_CLK_HZ = 20_000_000;
    localparam longint LCE_RECOVER_S = 4;
    localparam longint LCE_RETRY_S = 60;
    localparam longint LCE_TICK_MS = 1;
    localparam longint LCE_TICK_CYC = LCE_CLK_HZ / 1000 * LCE_TICK_MS;
    localparam longint LCE_RECOVER_TICKS = LCE_RECOVER_S * 1000 / LCE_TICK_MS;
    localparam longint LCE_RETRY_TICKS = LCE_RETRY_S * 1000 / LCE_TICK_MS;
    // ---------------------------------------------
    // types
    // ---------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] real_len_dm;
        logic wrong_way;
        logic reverse_traveler_tag;
        logic forward_direction_tag;
        logic dir_suffix;
    } lce_vehicle_t;
    typedef struct packed {
        logic relay_closed;
        logic oc_high;
    } lce_switch_t;
endpackage

//--- src/lce_tick.sv
// module: millisecond enable divider
`timescale 1ns/1ps
`default_nettype none
module lce_tick #(
    parameter int CYCLES = 20000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // enable
    output logic tick
);
    logic [31:0] cnt_reg, cnt_next;
    logic tick_reg, tick_next;
    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(CYCLES - 1)) begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign tick = tick_reg;
endmodule
`default_nettype wire

//--- src/lce_vehicle.sv
// module: per-vehicle length and direction evaluation
`timescale 1ns/1ps
`default_nettype none
module lce_vehicle
    import lce_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire logic [4:0] len_corr,
    input wire logic dir_en,
    input wire logic ww_en,
    input wire logic norm_rev,
    // measured passage
    input wire logic pass_valid,
    input wire logic [7:0] atten_len,
    input wire logic pass_rev,
    // result
    output lce_pkg::lce_vehicle_t veh
);
    lce_vehicle_t veh_reg, veh_next;
    logic [4:0] corr;
    logic opposed;
    always_comb begin
        corr = (len_corr > LCE_LENCORR_MAX) ? LCE_LENCORR_MAX : len_corr;
        opposed = pass_rev ^ norm_rev;
        veh_next = veh_reg;
        veh_next.valid = 1'b0;
        if (pass_valid) begin
            veh_next.valid = 1'b1;
            veh_next.real_len_dm = (atten_len > {3'h0, corr}) ?
                8'(atten_len - {3'h0, corr}) : 8'h00;
            veh_next.wrong_way = dir_en & ww_en & opposed;
            veh_next.reverse_traveler_tag = dir_en & ww_en & opposed;
            veh_next.forward_direction_tag = ~(dir_en & ww_en & opposed);
            veh_next.dir_suffix = pass_rev;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            veh_reg <= '0;
        end else begin
            veh_reg <= veh_next;
        end
    end
    assign veh = veh_reg;
endmodule
`default_nettype wire

//--- dv/lce_channel_monitor.sv
// checker: port-level properties of the loop channel
`timescale 1ns/1ps
`default_nettype none
module lce_channel_monitor
    import lce_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // front end
    input wire logic pass_valid,
    input wire logic pass_rev,
    input wire logic loop_occupied,
    input wire logic addr_wired,
    input wire logic [6:0] addr_pins,
    // outputs
    input wire logic oc_high,
    input wire logic relay_closed,
    input wire logic [6:0] bus_addr,
    input wire logic sens_reduced,
    input wire lce_pkg::lce_vehicle_t telegram
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_TEL_LAT: assert property (telegram.valid |-> $past(pass_valid, 1))
        else $error("telegram without passage");
    AST_WW_TAG: assert property (telegram.valid |-> telegram.reverse_traveler_tag == telegram.wrong_way)
        else $error("reverse tag differs from flag");
    AST_FWD_TAG: assert property (telegram.valid |-> telegram.forward_direction_tag != telegram.wrong_way)
        else $error("forward tag wrong");
    AST_SUFFIX: assert property (telegram.valid |-> telegram.dir_suffix == $past(pass_rev, 1))
        else $error("order suffix wrong");
    AST_OUT_PAIR: assert property (oc_high != relay_closed)
        else $error("collector and relay disagree");
    AST_HW_ADDR: assert property ((addr_wired && $stable(addr_wired) && $stable(addr_pins))[*6] |-> bus_addr == addr_pins)
        else $error("bus address not from pins");
    AST_RECOVER: assert property ($fell(sens_reduced) |-> !$past(loop_occupied, 8) && !$past(loop_occupied, 16))
        else $error("recovery too early");
    AST_IGNORED: assert property ((sens_reduced && loop_occupied)[*2] ##0 pass_valid |-> ##1 !telegram.valid)
        else $error("ignored vehicle reported");
endmodule
bind lce_channel lce_channel_monitor mon_u (
    .sys_clk(sys_clk), .rst(rst), .pass_valid(pass_valid), .pass_rev(pass_rev),
    .loop_occupied(loop_occupied), .addr_wired(addr_wired), .addr_pins(addr_pins),
    .oc_high(oc_high), .relay_closed(relay_closed), .bus_addr(bus_addr),
    .sens_reduced(sens_reduced), .telegram(telegram)
);
`default_nettype wire

//--- dv/lce_bus_master_model.sv
// partner: traffic data bus master collecting vehicle telegrams
`timescale 1ns/1ps
`default_nettype none
module lce_bus_master_model
    import lce_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // telegram stream
    input wire lce_pkg::lce_vehicle_t telegram,
    // collected data
    output var lce_pkg::lce_vehicle_t last_tel,
    output var logic [15:0] n_tel
);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            n_tel <= 16'h0000;
            last_tel <= '0;
        end else if (telegram.valid) begin
            last_tel <= telegram;
            n_tel <= n_tel + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// testbench: loop channel evaluation scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lce_pkg::*;
    logic sys_clk, pready, pslverr, oc_high, relay_closed, align_active, sens_reduced, e;
    logic rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pass_valid = 1'b0;
    logic pass_rev = 1'b0, loop_occupied = 1'b0, align_done = 1'b1, addr_wired = 1'b0;
    logic [7:0] paddr = 8'h00, atten_len = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] switch_on_thr = 16'h0064, n_tel;
    logic [6:0] addr_pins = 7'h00, bus_addr;
    lce_vehicle_t telegram, last_tel;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    lce_channel #(.TICK_CYC(4), .RECOVER_TICKS(5), .RETRY_TICKS(8)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_occupied(loop_occupied), .align_done(align_done), .switch_on_thr(switch_on_thr),
        .pass_valid(pass_valid), .atten_len(atten_len), .pass_rev(pass_rev),
        .addr_wired(addr_wired), .addr_pins(addr_pins), .oc_high(oc_high),
        .relay_closed(relay_closed), .bus_addr(bus_addr), .align_active(align_active),
        .sens_reduced(sens_reduced), .telegram(telegram));
    lce_bus_master_model mdl_u (.sys_clk(sys_clk), .rst(rst), .telegram(telegram),
        .last_tel(last_tel), .n_tel(n_tel));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, q & m);
    endtask
    task veh(input logic rev, input logic [7:0] al, input logic [7:0] len, input logic ww,
        input logic seen);
        logic [15:0] n0;
        n0 = n_tel;
        @(posedge sys_clk);
        pass_valid <= 1'b1;
        pass_rev <= rev;
        atten_len <= al;
        @(posedge sys_clk);
        pass_valid <= 1'b0;
        cycles(5);
        chk("tel_count", 32'(n0 + 16'(seen)), 32'(n_tel));
        if (seen) chk("telegram", {19'h0, 1'b1, len, ww, ww, ~ww, rev}, {19'h0, last_tel});
    endtask
    task outw(input logic oc);
        int k;
        for (k = 0; k < 20 && oc_high !== oc; k++) @(posedge sys_clk);
        chk("oc_high", 32'(oc), 32'(oc_high));
        chk("relay_closed", 32'(!oc), 32'(relay_closed));
    endtask
    task t_regs;
        rchk("ctrl_reset", LCE_ADDR_CTRL, 32'hFFFF_FFFF, LCE_CTRL_RESET);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped_err", 32'h1, 32'(e));
        chk("unmapped_data", 32'h0, q);
        apb(1'b1, LCE_ADDR_LENCORR, 32'h19);
        rchk("lencorr_clamp", LCE_ADDR_LENCORR, 32'h1F, 32'(LCE_LENCORR_MAX));
        apb(1'b1, LCE_ADDR_NOISE, 32'h1);
        rchk("noise_min", LCE_ADDR_NOISE, 32'hFFFF_0000, 32'h0019_0000);
        apb(1'b1, LCE_ADDR_NOISE, 32'h3E8);
        rchk("noise_max", LCE_ADDR_NOISE, 32'hFFFF_0000, 32'h00C8_0000);
        apb(1'b1, LCE_ADDR_NOISE, 32'h32);
        rchk("noise_mid", LCE_ADDR_NOISE, 32'hFFFF_0000, 32'h0032_0000);
        $display("t_regs done");
    endtask
    task t_addr;
        apb(1'b1, LCE_ADDR_ADDRCFG, 32'h2A);
        cycles(4);
        chk("bus_addr_cfg", 32'h2A, 32'(bus_addr));
        addr_wired <= 1'b1;
        addr_pins <= 7'h55;
        cycles(6);
        chk("bus_addr_pins", 32'h55, 32'(bus_addr));
        rchk("addr_report", LCE_ADDR_ADDRCFG, 32'h7F, 32'h55);
        addr_wired <= 1'b0;
        $display("t_addr done");
    endtask
    task t_len;
        apb(1'b1, LCE_ADDR_LENCORR, 32'h14);
        veh(1'b0, 8'h0F, 8'h00, 1'b0, 1'b1);
        veh(1'b0, 8'h64, 8'h50, 1'b0, 1'b1);
        apb(1'b1, LCE_ADDR_LENCORR, 32'h0);
        veh(1'b1, 8'hFF, 8'hFF, 1'b0, 1'b1);
        $display("t_len done");
    endtask
    task t_dir;
        int i;
        int r;
        for (i = 0; i < 8; i++) begin
            apb(1'b1, LCE_ADDR_CTRL, 32'(i));
            for (r = 0; r < 2; r++) begin
                veh(r[0], 8'h20, 8'h20, i[0] & i[1] & (r[0] ^ i[2]), 1'b1);
            end
        end
        $display("t_dir done");
    endtask
    task t_pol;
        apb(1'b1, LCE_ADDR_CTRL, 32'h2);
        outw(1'b1);
        loop_occupied <= 1'b1;
        outw(1'b0);
        apb(1'b1, LCE_ADDR_CTRL, 32'hA);
        outw(1'b1);
        loop_occupied <= 1'b0;
        outw(1'b0);
        apb(1'b1, LCE_ADDR_CTRL, 32'h2);
        $display("t_pol done");
    endtask
    task t_hold;
        int k;
        apb(1'b1, LCE_ADDR_HOLD, 32'h2);
        loop_occupied <= 1'b1;
        for (k = 0; k < 60 && sens_reduced !== 1'b1; k++) @(posedge sys_clk);
        chk("ignoring", 32'h1, 32'(sens_reduced));
        veh(1'b0, 8'h30, 8'h30, 1'b0, 1'b0);
        rchk("hold_expiries", LCE_ADDR_DIAG, 32'hFFFF, 32'h1);
        loop_occupied <= 1'b0;
        cycles(10);
        loop_occupied <= 1'b1;
        cycles(3);
        loop_occupied <= 1'b0;
        for (k = 0; k < 60 && sens_reduced === 1'b1; k++) @(posedge sys_clk);
        chk("recovery_cycles", 32'h1, 32'(k >= 16 && k <= 32));
        apb(1'b1, LCE_ADDR_HOLD, 32'h0);
        $display("t_hold done");
    endtask
    task t_fault;
        int k;
        logic w;
        align_done <= 1'b0;
        apb(1'b1, LCE_ADDR_CTRL, 32'h42);
        cycles(40);
        rchk("fault_off", LCE_ADDR_STATUS, 32'h2, 32'h0);
        apb(1'b1, LCE_ADDR_ALIGNMAX, 32'h2);
        for (k = 0; k < 20 && q[1] !== 1'b1; k++) apb(1'b0, LCE_ADDR_STATUS, 32'h0);
        chk("fault_on", 32'h1, 32'(q[1]));
        outw(1'b0);
        apb(1'b1, LCE_ADDR_CTRL, 32'h12);
        outw(1'b1);
        w = 1'b0;
        repeat (40) begin
            @(posedge sys_clk);
            w = w | align_active;
        end
        chk("no_retry", 32'h0, 32'(w));
        apb(1'b1, LCE_ADDR_CTRL, 32'h32);
        for (k = 0; k < 60 && align_active !== 1'b1; k++) @(posedge sys_clk);
        chk("retry", 32'h1, 32'(align_active));
        align_done <= 1'b1;
        apb(1'b1, LCE_ADDR_CTRL, 32'h2);
        apb(1'b1, LCE_ADDR_ALIGNMAX, 32'h0);
        $display("t_fault done");
    endtask
    initial begin
        cycles(10);
        rst <= 1'b0;
        cycles(20);
        t_regs;
        t_addr;
        t_len;
        t_dir;
        t_pol;
        t_hold;
        t_fault;
        give_verdict();
    end
endmodule
`default_nettype wire
